// file: hw/pie_gate.sv
// per-source masking and global gating of peripheral interrupt requests
// assumes flags are already in the ref_clk domain
`timescale 1ns/1ps
module pie_gate (
    pie_src_if.gate g
);
    import pie_pkg::*;

    // one and-gate per source: flag only counts while its enable is set
    genvar i;
    generate
        for (i = 0; i < SRC_N; i++) begin : g_src
            assign g.pend[i] = g.flag[i] & g.enable[i];
        end
    endgenerate

    // compat mode needs both globals; priority mode splits high and low
    always_comb begin
        if (!g.prio_mode) begin
            g.req_high = g.global_irq & g.global_periph & (|g.pend);
            g.req_low = 1'b0;
        end else begin
            g.req_high = g.global_irq & (|(g.pend & g.prio));
            g.req_low = g.global_periph & (|(g.pend & ~g.prio));
        end
    end
endmodule

// file: hw/pie_pkg.sv
// constants, register map and state type of the peripheral interrupt enable block
// assumes a 32-bit apb slave port and a 20 mhz ref_clk
package pie_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SRC_N = 16;
    localparam int EN_W = 8;
    localparam int CTRL_W = 3;
    // register byte offsets
    localparam logic [7:0] ADDR_ENABLE_1 = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_2 = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_PRIORITY_1 = 8'h0c;
    localparam logic [7:0] ADDR_PRIORITY_2 = 8'h10;
    localparam logic [7:0] ADDR_PENDING = 8'h14;
    // enable 1 field positions
    localparam int BIT_PARALLEL_PORT = 7;
    localparam int BIT_CONVERTER = 6;
    localparam int BIT_SERIAL_RX = 5;
    localparam int BIT_SERIAL_TX = 4;
    localparam int BIT_SYNC_SERIAL = 3;
    localparam int BIT_CAPTURE_COMPARE = 2;
    localparam int BIT_TIMER_B_MATCH = 1;
    localparam int BIT_TIMER_A_OVERFLOW = 0;
    // control field positions
    localparam int BIT_PRIORITY_MODE = 0;
    localparam int BIT_GLOBAL_PERIPH = 1;
    localparam int BIT_GLOBAL_IRQ = 2;
    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIORITY = 8'hff;
    localparam logic [2:0] RST_CONTROL = 3'h0;
    // program addresses
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;

    typedef struct packed {
        logic [EN_W-1:0] enable_1;
        logic [EN_W-1:0] enable_2;
        logic [CTRL_W-1:0] control;
        logic [EN_W-1:0] priority_1;
        logic [EN_W-1:0] priority_2;
        logic [DATA_W-1:0] rdata;
        logic slverr;
        logic irq;
        logic [15:0] vector;
    } pie_state_t;
endpackage

// file: hw/pie_src_if.sv
// bundle between the register block and the per-source gate
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface pie_src_if;
    logic [15:0] flag;
    logic [15:0] enable;
    logic [15:0] prio;
    logic prio_mode;
    logic global_periph;
    logic global_irq;
    logic [15:0] pend;
    logic req_high;
    logic req_low;
    modport gate (input flag, enable, prio, prio_mode, global_periph, global_irq,
        output pend, req_high, req_low);
    modport ctrl (output flag, enable, prio, prio_mode, global_periph, global_irq,
        input pend, req_high, req_low);
endinterface

// file: hw/pie_top.sv
// peripheral interrupt enable block with apb register access
// assumes peripheral flags are levels on ref_clk and the core samples irq_req
//
// Function
// - every enable bit of enable register 1 is read/write, zero after reset.
// - bit 7 passes the parallel port interrupt only while set.
// - bit 6 passes the converter completion interrupt when set.
// - bit 5 passes the serial receiver interrupt when set.
// - bit 4 passes the serial transmitter interrupt when set.
// - bit 3 passes the synchronous serial port interrupt when set.
// - bit 2 passes the capture/compare unit interrupt when set.
// - bit 1 passes the timer b period match interrupt when set.
// - bit 0 passes the timer a overflow interrupt when set.
// - without priority mode, the global peripheral enable must also be set.
// - peripheral enables are split over two separate enable registers.
// - reset fetch at 0000h, interrupts vector to 0008h or 0018h.
`timescale 1ns/1ps
module pie_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pie_pkg::ADDR_W-1:0] paddr,
    input wire logic [pie_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pie_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] periph_flag_1,
    input wire logic [7:0] periph_flag_2,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [15:0] reset_vector
);
    import pie_pkg::*;

    pie_state_t st_reg;
    pie_state_t st_next;
    pie_src_if src ();

    logic setup_ph;
    logic write_ph;
    logic mapped;

    // gate instance sees both enable registers as one source vector
    pie_gate u_gate (
        .g(src.gate)
    );

    assign src.flag = {periph_flag_2, periph_flag_1};
    assign src.enable = {st_reg.enable_2, st_reg.enable_1};
    assign src.prio = {st_reg.priority_2, st_reg.priority_1};
    assign src.prio_mode = st_reg.control[BIT_PRIORITY_MODE];
    assign src.global_periph = st_reg.control[BIT_GLOBAL_PERIPH];
    assign src.global_irq = st_reg.control[BIT_GLOBAL_IRQ];

    // apb phase decode
    assign setup_ph = psel & ~penable;
    assign write_ph = psel & penable & pwrite & pstrb[0];
    assign mapped = (paddr == ADDR_ENABLE_1) || (paddr == ADDR_ENABLE_2) ||
        (paddr == ADDR_CONTROL) || (paddr == ADDR_PRIORITY_1) ||
        (paddr == ADDR_PRIORITY_2) || (paddr == ADDR_PENDING);

    // next state: register writes, read capture, request and vector
    always_comb begin
        st_next = st_reg;
        if (write_ph) begin
            case (paddr)
                ADDR_ENABLE_1: st_next.enable_1 = pwdata[7:0];
                ADDR_ENABLE_2: st_next.enable_2 = pwdata[7:0];
                ADDR_CONTROL: st_next.control = pwdata[2:0];
                ADDR_PRIORITY_1: st_next.priority_1 = pwdata[7:0];
                ADDR_PRIORITY_2: st_next.priority_2 = pwdata[7:0];
                default: st_next.control = st_reg.control;
            endcase
        end
        if (setup_ph) begin
            st_next.slverr = ~mapped;
            case (paddr)
                ADDR_ENABLE_1: st_next.rdata = {24'h000000, st_reg.enable_1};
                ADDR_ENABLE_2: st_next.rdata = {24'h000000, st_reg.enable_2};
                ADDR_CONTROL: st_next.rdata = {29'h0, st_reg.control};
                ADDR_PRIORITY_1: st_next.rdata = {24'h000000, st_reg.priority_1};
                ADDR_PRIORITY_2: st_next.rdata = {24'h000000, st_reg.priority_2};
                ADDR_PENDING: st_next.rdata = {16'h0000, src.pend};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        // high priority wins the vector
        st_next.irq = src.req_high | src.req_low;
        if (src.req_high) begin
            st_next.vector = VEC_HIGH;
        end else if (src.req_low) begin
            st_next.vector = VEC_LOW;
        end else begin
            st_next.vector = VEC_HIGH;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.enable_1 <= RST_ENABLE;
            st_reg.enable_2 <= RST_ENABLE;
            st_reg.control <= RST_CONTROL;
            st_reg.priority_1 <= RST_PRIORITY;
            st_reg.priority_2 <= RST_PRIORITY;
            st_reg.rdata <= 32'h00000000;
            st_reg.slverr <= 1'b0;
            st_reg.irq <= 1'b0;
            st_reg.vector <= VEC_HIGH;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign prdata = st_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & st_reg.slverr;
    assign irq_req = st_reg.irq;
    assign irq_vector = st_reg.vector;
    assign reset_vector = VEC_RESET;

    // enable 1 write lands one edge later
    AST_EN1_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_ENABLE_1) |=> (st_reg.enable_1 == $past(pwdata[7:0])))
        else $error("enable 1 write lost");

    // enable 1 read returns stored value
    AST_EN1_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setup_ph && !pwrite && paddr == ADDR_ENABLE_1) |=> (prdata[7:0] == $past(st_reg.enable_1)))
        else $error("enable 1 read wrong");

    // parallel port alone cannot request while its enable is clear
    AST_PAR_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == 8'h80 && periph_flag_2 == 8'h00 && !st_reg.enable_1[BIT_PARALLEL_PORT]) |=> !irq_req)
        else $error("masked parallel port requested");

    // timer a overflow requests in compat mode when all gates open
    AST_TMA_PASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1[BIT_TIMER_A_OVERFLOW] && st_reg.enable_1[BIT_TIMER_A_OVERFLOW] &&
        st_reg.control == 3'h6) |=> (irq_req && irq_vector == VEC_HIGH))
        else $error("timer a overflow not requested");

    // pending of each enable 1 source follows flag and enable
    genvar k;
    generate
        for (k = 0; k < EN_W; k++) begin : g_chk
            AST_SRC_PEND: assert property (@(posedge ref_clk) disable iff (!rst_n)
                src.pend[k] == (periph_flag_1[k] && st_reg.enable_1[k]))
                else $error("pending bit does not follow enable");
        end
    endgenerate

    // compat mode with global peripheral enable clear never requests
    AST_GLOBAL_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!st_reg.control[BIT_PRIORITY_MODE] && !st_reg.control[BIT_GLOBAL_PERIPH]) |=> !irq_req)
        else $error("request without global peripheral enable");

    // write to enable 2 leaves enable 1 alone
    AST_SPLIT_REGS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_ENABLE_2) |=> $stable(st_reg.enable_1))
        else $error("enable 2 write disturbed enable 1");

    // vector is one of the two entry points and compat uses the high one
    AST_VECTOR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (irq_req && !$past(st_reg.control[BIT_PRIORITY_MODE])) |-> irq_vector == VEC_HIGH)
        else $error("compat vector wrong");

    // a request always has a pending enabled source behind it
    AST_REQ_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(irq_req) |-> $past(|src.pend))
        else $error("request without pending source");

    // parallel port alone requests exactly when its enable was set
    AST_PAR_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_PARALLEL_PORT) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_PARALLEL_PORT])))
        else $error("parallel port gate wrong");

    // converter completion alone requests exactly when its enable was set
    AST_CONV_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_CONVERTER) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_CONVERTER])))
        else $error("converter gate wrong");

    // serial receiver alone requests exactly when its enable was set
    AST_RX_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_SERIAL_RX) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_SERIAL_RX])))
        else $error("serial receiver gate wrong");

    // serial transmitter alone requests exactly when its enable was set
    AST_TX_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_SERIAL_TX) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_SERIAL_TX])))
        else $error("serial transmitter gate wrong");

    // synchronous serial port alone requests exactly when its enable was set
    AST_SYNC_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_SYNC_SERIAL) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_SYNC_SERIAL])))
        else $error("synchronous serial gate wrong");

    // capture/compare unit alone requests exactly when its enable was set
    AST_CAPCMP_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_CAPTURE_COMPARE) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_CAPTURE_COMPARE])))
        else $error("capture compare gate wrong");

    // timer b period match alone requests exactly when its enable was set
    AST_TMB_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_TIMER_B_MATCH) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_TIMER_B_MATCH])))
        else $error("timer b match gate wrong");

    // timer a overflow alone requests exactly when its enable was set
    AST_TMA_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (periph_flag_1 == (8'h01 << BIT_TIMER_A_OVERFLOW) && periph_flag_2 == 8'h00 && st_reg.control == 3'h6)
        |=> (irq_req == $past(st_reg.enable_1[BIT_TIMER_A_OVERFLOW])))
        else $error("timer a overflow gate wrong");

    // enable 2 write lands one edge later
    AST_EN2_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_ENABLE_2) |=> (st_reg.enable_2 == $past(pwdata[7:0])))
        else $error("enable 2 write lost");

    // enable 2 read returns stored value with zero upper bits
    AST_EN2_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setup_ph && !pwrite && paddr == ADDR_ENABLE_2) |=> (prdata == {24'h000000, $past(st_reg.enable_2)}))
        else $error("enable 2 read wrong");

    // write to enable 1 leaves enable 2 alone
    AST_SPLIT_REGS_REV: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_ENABLE_1) |=> $stable(st_reg.enable_2))
        else $error("enable 1 write disturbed enable 2");

    // control write lands one edge later
    AST_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_CONTROL) |=> (st_reg.control == $past(pwdata[2:0])))
        else $error("control write lost");

    // control read returns stored value
    AST_CTRL_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setup_ph && !pwrite && paddr == ADDR_CONTROL) |=> (prdata == {29'h0, $past(st_reg.control)}))
        else $error("control read wrong");

    // priority 2 write lands one edge later
    AST_PRIO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_PRIORITY_2) |=> (st_reg.priority_2 == $past(pwdata[7:0])))
        else $error("priority 2 write lost");

    // a write without the low byte strobe changes nothing
    AST_STRB_GUARD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && penable && pwrite && !pstrb[0]) |=> $stable(st_reg.enable_1))
        else $error("strobe-less write changed enable 1");

    // unmapped place reads zero and flags an error in its access phase
    AST_UNMAPPED_ERR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setup_ph && !mapped) |=> (prdata == 32'h00000000 && (!penable || pslverr)))
        else $error("unmapped access not refused");

    // mapped places never answer with an error
    AST_MAPPED_OK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setup_ph && mapped) |=> !pslverr)
        else $error("mapped access refused");

    // pending read shows flag and enable of every source
    AST_PEND_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setup_ph && !pwrite && paddr == ADDR_PENDING) |=>
        (prdata == {16'h0000, $past(periph_flag_2 & st_reg.enable_2), $past(periph_flag_1 & st_reg.enable_1)}))
        else $error("pending read wrong");

    // pending is read-only: a write there disturbs no register
    AST_PEND_RO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (write_ph && paddr == ADDR_PENDING) |=>
        ($stable(st_reg.enable_1) && $stable(st_reg.enable_2) && $stable(st_reg.control)))
        else $error("pending write changed a register");

    // no enabled flag means no request one edge later
    AST_NO_PEND: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (src.pend == 16'h0000) |=> !irq_req)
        else $error("request with nothing pending");

    // compat mode with both globals set passes any enabled flag
    AST_COMPAT_PASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!st_reg.control[BIT_PRIORITY_MODE] && st_reg.control[BIT_GLOBAL_PERIPH] &&
        st_reg.control[BIT_GLOBAL_IRQ] && src.pend != 16'h0000) |=> (irq_req && irq_vector == VEC_HIGH))
        else $error("enabled source not requested in compat mode");

    // priority mode: a high source with the global enable takes the high vector
    AST_HIGH_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.control[BIT_PRIORITY_MODE] && st_reg.control[BIT_GLOBAL_IRQ] &&
        (src.pend & src.prio) != 16'h0000) |=> (irq_req && irq_vector == VEC_HIGH))
        else $error("high priority source not on the high vector");

    // priority mode: a low source alone takes the low vector
    AST_LOW_VECTOR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.control[BIT_PRIORITY_MODE] && st_reg.control[BIT_GLOBAL_PERIPH] &&
        (src.pend & ~src.prio) != 16'h0000 &&
        !(st_reg.control[BIT_GLOBAL_IRQ] && (src.pend & src.prio) != 16'h0000))
        |=> (irq_req && irq_vector == VEC_LOW))
        else $error("low priority source not on the low vector");

    // priority mode: low sources stay silent without the global peripheral enable
    AST_LOW_NEEDS_PERIPH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.control[BIT_PRIORITY_MODE] && !st_reg.control[BIT_GLOBAL_PERIPH] &&
        (src.pend & src.prio) == 16'h0000) |=> !irq_req)
        else $error("low priority request without global peripheral enable");

    // idle vector rests on the high entry point
    AST_IDLE_VECTOR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !irq_req |-> (irq_vector == VEC_HIGH))
        else $error("idle vector wrong");
endmodule

// file: sim/pie_periph_model.sv
// behavioural model of the peripherals that raise the interrupt flags
// assumes the bench calls set_flags and that flags are levels on ref_clk
`timescale 1ns/1ps
module pie_periph_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic [7:0] flag_1,
    output logic [7:0] flag_2
);
    // flags start low, and set_flags drives them low if called while the device is held in reset
    initial begin
        flag_1 = 8'h00;
        flag_2 = 8'h00;
    end

    // flags change just after a rising edge, like real peripheral logic
    task automatic set_flags(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        flag_1 <= rst_n ? a : 8'h00;
        flag_2 <= rst_n ? b : 8'h00;
    endtask
endmodule

// file: sim/pie_tb_top.sv
// register and gating tests of the peripheral interrupt enable block
// assumes pie_top, pie_pkg and the flag model are compiled first
`timescale 1ns/1ps
module pie_tb_top;
    import pie_pkg::*;
    localparam int TIMEOUT_CYC = 8000;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] flag_1;
    logic [7:0] flag_2;
    logic irq_req;
    logic [15:0] irq_vector;
    logic [15:0] reset_vector;
    logic [DATA_W-1:0] rd;
    logic err;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    pie_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_flag_1(flag_1), .periph_flag_2(flag_2), .irq_req(irq_req),
        .irq_vector(irq_vector), .reset_vector(reset_vector));
    pie_periph_model src (.ref_clk(ref_clk), .rst_n(rst_n), .flag_1(flag_1), .flag_2(flag_2));

    // 20 mhz clock
    always #25 ref_clk = ~ref_clk;

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == TIMEOUT_CYC) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? s : 4'h0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(what, exp, rd);
    endtask

    // output level two edges after the last change
    task automatic irq_chk(input logic req, input logic [15:0] vec);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq_req", {31'h0, req}, {31'h0, irq_req});
        chk("irq_vector", {16'h0, vec}, {16'h0, irq_vector});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset state
        rd_chk("enable_1", ADDR_ENABLE_1, 32'h0);
        rd_chk("enable_2", ADDR_ENABLE_2, 32'h0);
        chk("reset_vector", 32'h0, {16'h0, reset_vector});
        chk("pready", 32'h1, {31'h0, pready});
        // read and write back, plus a strobe-less write that must be ignored
        apb(1'b1, ADDR_ENABLE_1, 32'ha5, 4'hf);
        rd_chk("enable_1", ADDR_ENABLE_1, 32'ha5);
        apb(1'b1, ADDR_ENABLE_1, 32'h5a, 4'h0);
        rd_chk("enable_1", ADDR_ENABLE_1, 32'ha5);
        apb(1'b1, ADDR_ENABLE_1, 32'h5a, 4'hf);
        rd_chk("enable_1", ADDR_ENABLE_1, 32'h5a);
        // unmapped place answers with an error and zero data
        apb(1'b0, 8'h40, 32'h0, 4'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        // each enable 1 bit passes only its own source
        apb(1'b1, ADDR_CONTROL, 32'h6, 4'hf);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_ENABLE_1, 32'h1 << i, 4'hf);
            src.set_flags(~(8'h01 << i), 8'h00);
            irq_chk(1'b0, VEC_HIGH);
            src.set_flags(8'h01 << i, 8'h00);
            irq_chk(1'b1, VEC_HIGH);
        end
        // global peripheral enable gates everything without priority mode
        apb(1'b1, ADDR_CONTROL, 32'h4, 4'hf);
        irq_chk(1'b0, VEC_HIGH);
        apb(1'b1, ADDR_CONTROL, 32'h6, 4'hf);
        irq_chk(1'b1, VEC_HIGH);
        // second register source, high then low priority vector
        apb(1'b1, ADDR_ENABLE_1, 32'h0, 4'hf);
        apb(1'b1, ADDR_ENABLE_2, 32'h08, 4'hf);
        src.set_flags(8'h00, 8'h08);
        apb(1'b1, ADDR_CONTROL, 32'h5, 4'hf);
        irq_chk(1'b1, VEC_HIGH);
        rd_chk("pending", ADDR_PENDING, 32'h0800);
        rd_chk("control", ADDR_CONTROL, 32'h5);
        // pending is read-only
        apb(1'b1, ADDR_PENDING, 32'hff, 4'hf);
        rd_chk("enable_2", ADDR_ENABLE_2, 32'h08);
        apb(1'b1, ADDR_PRIORITY_2, 32'h0, 4'hf);
        irq_chk(1'b0, VEC_HIGH);
        apb(1'b1, ADDR_CONTROL, 32'h3, 4'hf);
        irq_chk(1'b1, VEC_LOW);
        src.set_flags(8'h00, 8'h00);
        irq_chk(1'b0, VEC_HIGH);
        // mid-run reset clears every enable and drops a standing request
        apb(1'b1, ADDR_ENABLE_1, 32'hff, 4'hf);
        src.set_flags(8'h00, 8'h08);
        irq_chk(1'b1, VEC_LOW);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq_req", 32'h0, {31'h0, irq_req});
        chk("irq_vector", {16'h0, VEC_HIGH}, {16'h0, irq_vector});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk("enable_1", ADDR_ENABLE_1, 32'h0);
        rd_chk("enable_2", ADDR_ENABLE_2, 32'h0);
        rd_chk("control", ADDR_CONTROL, 32'h0);
        rd_chk("priority_2", ADDR_PRIORITY_2, {24'h0, RST_PRIORITY});
        irq_chk(1'b0, VEC_HIGH);
        tally_and_finish();
    end
endmodule
